// *** verilog/fspc_pkg.sv ***
// package: register map, field layout and timing constants for the page/status block
package fspc_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam logic [7:0] OFF_SECT_PROT = 8'hc0;
    localparam logic [7:0] OFF_SECURITY = 8'hc2;
    localparam logic [7:0] OFF_PMR0 = 8'hb0;
    localparam logic [7:0] OFF_PMR2 = 8'hb4;
    localparam logic [7:0] OFF_FLASH_CMD = 8'hc4;
    localparam logic [7:0] OFF_FLASH_STAT = 8'hc6;
    localparam logic [7:0] OFF_PAGE = 8'he0;
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [7:0] PMR_RST = 8'h00;
    localparam logic [7:0] RESET_CODE = 8'hf0;
    localparam int unsigned LOCK_BIT = 7;
    localparam int unsigned TURBO_BIT = 3;
    localparam int unsigned FLASH_RESET_US = 2000;
    localparam int unsigned FLASH_RESET_CYC = (FLASH_RESET_US * (CLK_HZ / 1000000));
    localparam int unsigned STANDBY_NS = 70;
    localparam int unsigned STANDBY_CYC = (STANDBY_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned N_CTRL = 5;

    typedef enum logic [4:0] {
        FSPC_IDLE = 5'h01,
        FSPC_PROG = 5'h02,
        FSPC_BULK = 5'h04,
        FSPC_SECT = 5'h08,
        FSPC_RCVR = 5'h10
    } fspc_state_e;

    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [7:0] offset;
        logic [7:0] wdata;
    } fspc_bus_s;

    typedef struct packed {
        logic prog_start;
        logic bulk_start;
        logic sect_start;
        logic [7:0] target;
        logic done;
    } fspc_op_s;
endpackage : fspc_pkg

// *** verilog/fspc_sync.sv ***
// two-flop synchroniser for pin-level inputs
`timescale 1ns/100ps
module fspc_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : fspc_sync

// *** verilog/fspc_top.sv ***
// page register, protection/security status, flash reset and power-mode control
`timescale 1ns/100ps
// Function
// - protect status bit i mirrors sector i
// - security lock shown in bit 7 only
// - host cannot change the lock
// - lock blocks programmer access to flash/config
// - lock cleared only by whole-device erase; reset_n low also clears lock_r
// - host flash reads unaffected by lock
// - single-write reset returns flash to read
// - reset completion takes up to milliseconds
// - reset ignored during program or bulk erase
// - reset aborts sector erase
// - page register 8-bit, writable and readable
// - page outputs feed the address decoder
// - page register sits at offset e0
// - page outputs clear at reset
// - all page bits reach general logic
// - turbo bit zero enables 70 ns standby
// - three bits block host control signals
// - one select for 256-byte control block
// - protection bits read-only to host
// - program/erase to protected sector ignored
module fspc_top #(
    parameter int unsigned RESET_CYC = fspc_pkg::FLASH_RESET_CYC,
    parameter int unsigned NSECT = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [15:0] host_addr,
    input wire logic [7:0] csr_base,
    input wire logic host_wr_n,
    input wire logic host_rd_n,
    input wire logic [7:0] internal_data_lines,
    output logic [7:0] rdata_r,
    output logic rdata_oe_r,
    input wire logic [2:0] host_ctrl,
    input wire logic [NSECT-1:0] nv_protect,
    input wire logic nv_lock,
    input wire logic prog_req,
    input wire logic bulk_req,
    input wire logic sect_req,
    input wire logic [NSECT-1:0] op_sector,
    input wire logic flash_op_done,
    input wire logic programmer_req,
    input wire logic device_erase_done,
    output logic [7:0] page_outputs_r,
    output logic [7:0] general_logic_page_r,
    output logic csr_select_r,
    output logic [NSECT-1:0] sector_selects_r,
    output logic flash_read_mode_r,
    output logic flash_busy_r,
    output logic flash_abort_r,
    output logic prog_go_r,
    output logic bulk_go_r,
    output logic sect_go_r,
    output logic programmer_grant_r,
    output logic lock_r,
    output logic [2:0] array_ctrl_r,
    output logic array_standby_r
);
    logic [15:0] addr_s;
    logic wr_n_s;
    logic rd_n_s;
    logic [7:0] data_s;
    logic [2:0] ctrl_s;
    logic [NSECT-1:0] prot_s;
    logic lock_s;
    logic wr_d_r;
    logic rd_d_r;
    logic wr_pulse;
    logic rd_pulse;
    fspc_pkg::fspc_bus_s bus;
    logic [7:0] pmr0_r;
    logic [7:0] pmr2_r;
    logic [NSECT-1:0] prot_r;
    fspc_pkg::fspc_state_e state_r;
    logic [31:0] rcv_cnt_r;
    logic [2:0] ctrl_d_r;
    logic [7:0] page_d_r;
    logic [7:0] idle_cnt_r;
    logic reset_cmd;
    logic [7:0] rd_nxt;

    function automatic logic hit(input logic [7:0] off, input logic [7:0] want);
        hit = (off == want);
    endfunction : hit

    fspc_sync #(.W(16 + 1 + 1 + 8 + 3 + NSECT + 1)) u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .d({host_addr, host_wr_n, host_rd_n, internal_data_lines, host_ctrl, nv_protect, nv_lock}),
        .q({addr_s, wr_n_s, rd_n_s, data_s, ctrl_s, prot_s, lock_s})
    );

    // decoder: csr block spans 256 bytes from programmable base
    always_comb
    begin
        bus.sel = (addr_s[15:8] == csr_base);
        bus.offset = addr_s[7:0];
        bus.wdata = data_s;
        bus.wr = bus.sel && wr_pulse;
        bus.rd = bus.sel && rd_pulse;
    end

    assign wr_pulse = !wr_n_s && wr_d_r;
    assign rd_pulse = !rd_n_s && rd_d_r;
    assign reset_cmd = bus.wr && hit(bus.offset, fspc_pkg::OFF_FLASH_CMD)
        && (bus.wdata == fspc_pkg::RESET_CODE);

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            wr_d_r <= 1'b1;
            rd_d_r <= 1'b1;
        end
        else
        begin
            wr_d_r <= wr_n_s;
            rd_d_r <= rd_n_s;
        end
    end

    // page register
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            page_outputs_r <= fspc_pkg::PAGE_RST;
        else if (bus.wr && hit(bus.offset, fspc_pkg::OFF_PAGE))
            page_outputs_r <= bus.wdata;
    end

    // page bits mirrored to general logic; decoder selects use page
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            general_logic_page_r <= fspc_pkg::PAGE_RST;
            sector_selects_r <= '0;
            csr_select_r <= 1'b0;
        end
        else
        begin
            general_logic_page_r <= page_outputs_r;
            csr_select_r <= bus.sel;
            // sector i selected by page value when host not in csr block
            for (int i = 0; i < NSECT; i++)
                sector_selects_r[i] <= !bus.sel && (page_outputs_r[2:0] == 3'(i));
        end
    end

    // power-mode registers
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            pmr0_r <= fspc_pkg::PMR_RST;
            pmr2_r <= fspc_pkg::PMR_RST;
        end
        else if (bus.wr && hit(bus.offset, fspc_pkg::OFF_PMR0))
            pmr0_r <= bus.wdata;
        else if (bus.wr && hit(bus.offset, fspc_pkg::OFF_PMR2))
            pmr2_r <= bus.wdata;
    end

    // control-signal blocking and standby detection
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            array_ctrl_r <= '0;
            ctrl_d_r <= '0;
            page_d_r <= '0;
            idle_cnt_r <= '0;
            array_standby_r <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
                array_ctrl_r[i] <= ctrl_s[i] && !pmr2_r[i];
            ctrl_d_r <= ctrl_s;
            page_d_r <= page_outputs_r;
            if ((ctrl_s != ctrl_d_r) || (page_outputs_r != page_d_r) || pmr0_r[fspc_pkg::TURBO_BIT])
            begin
                idle_cnt_r <= '0;
                array_standby_r <= 1'b0;
            end
            else if (idle_cnt_r >= 8'(fspc_pkg::STANDBY_CYC))
                array_standby_r <= 1'b1;
            else
                idle_cnt_r <= idle_cnt_r + 8'h01;
        end
    end

    // protection and security latched from nonvolatile straps, not host
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            prot_r <= '0;
            lock_r <= 1'b0;
        end
        else
        begin
            prot_r <= prot_s;
            // erase has priority; the strap copy of the lock lags by two cycles
            if (device_erase_done)
                lock_r <= 1'b0;
            else if (lock_s)
                lock_r <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            programmer_grant_r <= 1'b0;
        else
            programmer_grant_r <= programmer_req && !lock_r;
    end

    // flash command state machine
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            state_r <= fspc_pkg::FSPC_IDLE;
            rcv_cnt_r <= '0;
            prog_go_r <= 1'b0;
            bulk_go_r <= 1'b0;
            sect_go_r <= 1'b0;
            flash_abort_r <= 1'b0;
        end
        else
        begin
            prog_go_r <= 1'b0;
            bulk_go_r <= 1'b0;
            sect_go_r <= 1'b0;
            flash_abort_r <= 1'b0;
            case (state_r)
                fspc_pkg::FSPC_IDLE:
                begin
                    if (reset_cmd)
                    begin
                        state_r <= fspc_pkg::FSPC_RCVR;
                        rcv_cnt_r <= '0;
                    end
                    else if (prog_req && ((op_sector & prot_r) == '0))
                    begin
                        state_r <= fspc_pkg::FSPC_PROG;
                        prog_go_r <= 1'b1;
                    end
                    else if (bulk_req && (prot_r == '0))
                    begin
                        state_r <= fspc_pkg::FSPC_BULK;
                        bulk_go_r <= 1'b1;
                    end
                    else if (sect_req && ((op_sector & prot_r) == '0))
                    begin
                        state_r <= fspc_pkg::FSPC_SECT;
                        sect_go_r <= 1'b1;
                    end
                end
                fspc_pkg::FSPC_PROG, fspc_pkg::FSPC_BULK:
                begin
                    if (flash_op_done)
                        state_r <= fspc_pkg::FSPC_IDLE;
                end
                fspc_pkg::FSPC_SECT:
                begin
                    if (reset_cmd)
                    begin
                        flash_abort_r <= 1'b1;
                        state_r <= fspc_pkg::FSPC_RCVR;
                        rcv_cnt_r <= '0;
                    end
                    else if (flash_op_done)
                        state_r <= fspc_pkg::FSPC_IDLE;
                end
                fspc_pkg::FSPC_RCVR:
                begin
                    if (rcv_cnt_r >= RESET_CYC - 1)
                        state_r <= fspc_pkg::FSPC_IDLE;
                    else
                        rcv_cnt_r <= rcv_cnt_r + 32'h1;
                end
                default:
                    state_r <= fspc_pkg::FSPC_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            flash_read_mode_r <= 1'b1;
            flash_busy_r <= 1'b0;
        end
        else
        begin
            flash_read_mode_r <= (state_r == fspc_pkg::FSPC_IDLE);
            flash_busy_r <= (state_r != fspc_pkg::FSPC_IDLE);
        end
    end

    // read mux; writes to status offsets fall through with no effect
    always_comb
    begin
        rd_nxt = 8'h00;
        case (bus.offset)
            fspc_pkg::OFF_PAGE: rd_nxt = page_outputs_r;
            fspc_pkg::OFF_SECT_PROT: rd_nxt = prot_r;
            fspc_pkg::OFF_SECURITY: rd_nxt = {lock_r, 7'h00};
            fspc_pkg::OFF_PMR0: rd_nxt = pmr0_r;
            fspc_pkg::OFF_PMR2: rd_nxt = pmr2_r;
            fspc_pkg::OFF_FLASH_STAT: rd_nxt = {7'h00, flash_busy_r};
            default: rd_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            rdata_r <= 8'h00;
            rdata_oe_r <= 1'b0;
        end
        else
        begin
            // captured once per read strobe, held until the next read
            if (bus.rd)
                rdata_r <= rd_nxt;
            rdata_oe_r <= bus.sel && !rd_n_s;
        end
    end
endmodule : fspc_top

// *** dv/fspc_assertions.sv ***
// checker: page, lock and flash reset relations at the fspc_top ports
`timescale 1ns/100ps
module fspc_assertions #(
    parameter int unsigned RESET_CYC = 10
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic host_wr_n,
    input wire logic host_rd_n,
    input wire logic flash_op_done,
    input wire logic device_erase_done,
    input wire logic [7:0] rdata_r,
    input wire logic [7:0] page_outputs_r,
    input wire logic [7:0] general_logic_page_r,
    input wire logic flash_read_mode_r,
    input wire logic flash_abort_r,
    input wire logic prog_go_r,
    input wire logic bulk_go_r,
    input wire logic programmer_grant_r,
    input wire logic lock_r
);
    localparam int RWIN = RESET_CYC + 8;
    logic run_r;
    logic [3:0] erase_hist_r;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    // program or bulk erase in flight
    always_ff @(posedge ref_clk)
        if (!reset_n || flash_op_done)
            run_r <= 1'b0;
        else if (prog_go_r || bulk_go_r)
            run_r <= 1'b1;
    // recent whole-device erase pulses, covers sync lag
    always_ff @(posedge ref_clk)
        if (!reset_n)
            erase_hist_r <= 4'h0;
        else
            erase_hist_r <= {erase_hist_r[2:0], device_erase_done};
    a_page_reset: assert property (disable iff (1'b0) !reset_n |=> page_outputs_r == 8'h00)
        else $error("page outputs not cleared by reset");
    a_page_copy: assert property (general_logic_page_r == $past(page_outputs_r))
        else $error("general logic page copy wrong");
    a_page_write: assert property (!$stable(page_outputs_r) |-> !$past(host_wr_n, 2) || !$past(host_wr_n, 3))
        else $error("page changed without a write");
    a_rdata_hold: assert property (!$stable(rdata_r) |-> !$past(host_rd_n, 2) || !$past(host_rd_n, 3))
        else $error("read data changed without a read");
    a_abort_read: assert property (flash_abort_r |-> ##[1:RWIN] flash_read_mode_r)
        else $error("read mode late after abort");
    a_run_noabort: assert property (run_r |-> !flash_abort_r)
        else $error("reset aborted program or bulk erase");
    a_lock_block: assert property (lock_r [*2] |-> !programmer_grant_r)
        else $error("programmer granted while locked");
    a_lock_clear: assert property ($fell(lock_r) |-> |erase_hist_r)
        else $error("lock cleared without device erase");
endmodule : fspc_assertions

bind fspc_top fspc_assertions #(.RESET_CYC(RESET_CYC)) u_chk (.ref_clk, .reset_n, .host_wr_n, .host_rd_n,
    .flash_op_done, .device_erase_done, .rdata_r, .page_outputs_r, .general_logic_page_r, .flash_read_mode_r,
    .flash_abort_r, .prog_go_r, .bulk_go_r, .programmer_grant_r, .lock_r);

// *** dv/fspc_host_bfm.sv ***
// host bus model: byte writes and reads to the control block
`timescale 1ns/100ps
module fspc_host_bfm (
    input wire logic ref_clk,
    input wire logic [7:0] csr_base,
    input wire logic [7:0] rdata_r,
    output logic [15:0] host_addr,
    output logic host_wr_n,
    output logic host_rd_n,
    output logic [7:0] internal_data_lines
);
    initial
    begin
        host_addr = 16'h0000;
        host_wr_n = 1'b1;
        host_rd_n = 1'b1;
        internal_data_lines = 8'h00;
    end
    // strobe low and high at least four cycles each; data inverted once released
    task automatic acc(input logic wr, input logic [7:0] off, input logic [7:0] wd, output logic [7:0] rd,
        input int slow);
        @(negedge ref_clk);
        host_addr = {csr_base, off};
        internal_data_lines = wd;
        host_wr_n = !wr;
        host_rd_n = wr;
        repeat (4 + slow) @(negedge ref_clk);
        rd = rdata_r;
        host_wr_n = 1'b1;
        host_rd_n = 1'b1;
        internal_data_lines = ~wd;
        repeat (4 + slow) @(negedge ref_clk);
    endtask : acc
endmodule : fspc_host_bfm

// *** dv/testbench.sv ***
// testbench: register access, flash reset cases, power mode and lock for fspc_top
`timescale 1ns/100ps
module testbench;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] csr_base = 8'h10;
    logic [2:0] host_ctrl = 3'h5;
    logic [7:0] nv_protect = 8'h96;
    logic nv_lock = 1'b0;
    logic prog_req = 1'b0;
    logic bulk_req = 1'b0;
    logic sect_req = 1'b0;
    logic [7:0] op_sector = 8'h01;
    logic flash_op_done = 1'b0;
    logic programmer_req = 1'b1;
    logic device_erase_done = 1'b0;
    logic [15:0] host_addr;
    logic host_wr_n, host_rd_n, flash_read_mode_r, flash_busy_r, flash_abort_r, prog_go_r, bulk_go_r, sect_go_r;
    logic [7:0] internal_data_lines, rdata_r, page_outputs_r, general_logic_page_r, rd;
    logic programmer_grant_r, lock_r, array_standby_r, csr_select_r, rdata_oe_r;
    logic [7:0] sector_selects_r;
    logic oe_seen = 1'b0;
    logic [2:0] array_ctrl_r;
    logic [3:0] seen = 4'h0;
    wire [4:0] mon = {seen, flash_read_mode_r};
    int fail_count = 0;
    int checks = 0;
    // offset, write data, expected read back
    logic [23:0] rows [5] = '{24'he0a5a5, 24'he05a5a, 24'hc0ff96, 24'hc2ff00, 24'h33ff00};

    always #10 ref_clk = ~ref_clk;
    // pulses may land inside a bus cycle, so they are kept
    always @(posedge ref_clk) seen <= seen | {sect_go_r, bulk_go_r, flash_abort_r, flash_busy_r};
    always @(posedge ref_clk) oe_seen <= oe_seen | rdata_oe_r;

    fspc_top #(.RESET_CYC(10)) dut (.ref_clk, .reset_n, .host_addr, .csr_base, .host_wr_n, .host_rd_n,
        .internal_data_lines, .rdata_r, .rdata_oe_r, .host_ctrl, .nv_protect, .nv_lock, .prog_req, .bulk_req,
        .sect_req, .op_sector, .flash_op_done, .programmer_req, .device_erase_done, .page_outputs_r,
        .general_logic_page_r, .csr_select_r, .sector_selects_r, .flash_read_mode_r, .flash_busy_r,
        .flash_abort_r, .prog_go_r, .bulk_go_r, .sect_go_r, .programmer_grant_r, .lock_r, .array_ctrl_r,
        .array_standby_r);
    fspc_host_bfm host (.ref_clk, .csr_base, .rdata_r, .host_addr, .host_wr_n, .host_rd_n, .internal_data_lines);

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wt(input int k, input logic v, input int n);
        for (int i = 0; i < n && mon[k] !== v; i++)
            @(negedge ref_clk);
        chk({7'h0, mon[k]}, {7'h0, v});
        if (mon[k] !== v)
            stop_test();
    endtask : wt

    initial
    begin
        repeat (8) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        foreach (rows[i])
        begin
            host.acc(1'b1, rows[i][23:16], rows[i][15:8], rd, 0);
            host.acc(1'b0, rows[i][23:16], 8'h00, rd, i % 2);
            chk(rd, rows[i][7:0]);
        end
        chk(page_outputs_r, 8'h5a);
        chk(general_logic_page_r, 8'h5a);
        chk({7'h0, oe_seen}, 8'h01);
        chk({7'h0, csr_select_r}, 8'h01);
        chk(sector_selects_r, 8'h00);
        csr_base = 8'h20;
        repeat (2) @(negedge ref_clk);
        chk({7'h0, csr_select_r}, 8'h00);
        chk(sector_selects_r, 8'h04);
        csr_base = 8'h10;
        repeat (2) @(negedge ref_clk);
        seen = 4'h0;
        host.acc(1'b1, 8'hc4, 8'hf0, rd, 0);
        wt(1, 1'b1, 20);
        wt(0, 1'b1, 40);
        seen = 4'h0;
        sect_req = 1'b1;
        wt(4, 1'b1, 20);
        sect_req = 1'b0;
        host.acc(1'b1, 8'hc4, 8'hf0, rd, 1);
        wt(2, 1'b1, 20);
        wt(0, 1'b1, 40);
        seen = 4'h0;
        bulk_req = 1'b1;
        repeat (5) @(negedge ref_clk);
        chk({4'h0, seen}, 8'h00);
        nv_protect = 8'h00;
        wt(3, 1'b1, 20);
        bulk_req = 1'b0;
        nv_protect = 8'h96;
        host.acc(1'b1, 8'hc4, 8'hf0, rd, 0);
        repeat (20) @(negedge ref_clk);
        chk({6'h0, seen[1], flash_busy_r}, 8'h01);
        flash_op_done = 1'b1;
        @(negedge ref_clk);
        flash_op_done = 1'b0;
        repeat (30) @(negedge ref_clk);
        seen = 4'h0;
        op_sector = 8'h02;
        prog_req = 1'b1;
        repeat (10) @(negedge ref_clk);
        prog_req = 1'b0;
        chk({4'h0, seen}, 8'h00);
        op_sector = 8'h01;
        prog_req = 1'b1;
        wt(1, 1'b1, 20);
        prog_req = 1'b0;
        host.acc(1'b1, 8'hc4, 8'hf0, rd, 0);
        chk({6'h0, seen[1], flash_busy_r}, 8'h01);
        flash_op_done = 1'b1;
        @(negedge ref_clk);
        flash_op_done = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk({7'h0, flash_read_mode_r}, 8'h01);
        host.acc(1'b1, 8'hb4, 8'h07, rd, 0);
        chk({5'h0, array_ctrl_r}, 8'h00);
        host.acc(1'b1, 8'hb4, 8'h00, rd, 0);
        chk({5'h0, array_ctrl_r}, 8'h05);
        repeat (10) @(negedge ref_clk);
        chk({7'h0, array_standby_r}, 8'h01);
        host.acc(1'b1, 8'hb0, 8'h08, rd, 0);
        repeat (10) @(negedge ref_clk);
        chk({7'h0, array_standby_r}, 8'h00);
        nv_lock = 1'b1;
        repeat (6) @(negedge ref_clk);
        chk({lock_r, programmer_grant_r, 6'h0}, 8'h80);
        host.acc(1'b1, 8'hc2, 8'h00, rd, 0);
        host.acc(1'b0, 8'hc2, 8'h00, rd, 0);
        chk(rd, 8'h80);
        nv_lock = 1'b0;
        repeat (6) @(negedge ref_clk);
        chk({7'h0, lock_r}, 8'h01);
        device_erase_done = 1'b1;
        @(negedge ref_clk);
        device_erase_done = 1'b0;
        repeat (6) @(negedge ref_clk);
        chk({lock_r, programmer_grant_r, 6'h0}, 8'h40);
        host.acc(1'b1, 8'he0, 8'hff, rd, 0);
        chk(page_outputs_r, 8'hff);
        reset_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(page_outputs_r, 8'h00);
        reset_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk({7'h0, flash_read_mode_r}, 8'h01);
        stop_test();
    end
endmodule : testbench
